// >>> ccc_pkg.sv
// package for the clamp and coast control block
// assumes: used by ccc_top and tb only
`default_nettype none
package ccc_pkg;
  localparam int unsigned CNT_W         = 8;
  localparam logic        CLAMP_SRC_RST = 1'b0;
  localparam logic        CLAMP_POL_RST = 1'b1;
  localparam logic        HOLD_POL_RST  = 1'b1;
  localparam logic        SYNC_POL_RST  = 1'b0;
  localparam logic [7:0]  DLY_RST       = 8'h09;
  localparam logic [7:0]  DUR_RST       = 8'h14;

  typedef struct packed {
    logic       clamp_src;
    logic       clamp_pol;
    logic       hold_pol;
    logic       sync_pol;
    logic [7:0] clamp_dly;
    logic [7:0] clamp_dur;
  } ccc_cfg_t;

  typedef enum logic [1:0] {
    CCC_IDLE  = 2'b00,
    CCC_DELAY = 2'b01,
    CCC_CLAMP = 2'b10
  } ccc_state_t;
endpackage : ccc_pkg
`default_nettype wire

// >>> ccc_sync.sv
// two flip-flop level synchroniser
// assumes: din is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module ccc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_width_chk
    $error("ccc_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : ccc_sync
`default_nettype wire

// >>> ccc_top.sv
// clamp window and pll hold control, pixel clock domain
// assumes: ref_clk is the pixel clock; pins are asynchronous; cfg static-ish
// What this block does
// - source bit 1: clamp follows external window
// - clamp source bit resets to zero
// - source 0: count delay, duration after sync
// - external clamp window sense set by polarity bit
// - hold active: stop tracking, keep frequency
// - hold sense set by hold polarity bit
// - hold polarity bit resets to one
// - track and lead strobes on leading sync edge only, sense selectable
// - delay and duration are 8-bit pixel counts
`timescale 1ns/1ps
`default_nettype none
module ccc_top #(
  parameter int unsigned CW = ccc_pkg::CNT_W
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             clamp_pin,
  input  wire logic             hold_pin,
  input  wire logic             sync_pin,
  input  wire ccc_pkg::ccc_cfg_t cfg,
  input  wire logic             cfg_we,
  output var  logic             clamp_q,
  output var  logic             hold_q,
  output var  logic             track_q,
  output var  logic             lead_q,
  output var  ccc_pkg::ccc_cfg_t cfg_q
);
  logic [2:0]       pin_s;
  logic             sync_d1_q;
  logic             lead_edge;
  logic             trail_edge;
  logic [CW-1:0]    cnt_q;
  ccc_pkg::ccc_state_t st_q;
  logic             int_clamp;
  logic             ext_clamp;
  logic             hold_act;
  logic [2:0]       fill_q;

  if (CW != ccc_pkg::CNT_W) begin : g_cw_chk
    $error("ccc_top: CW must equal 8");
  end

  function automatic logic sensed(input logic lvl, input logic pol);
    sensed = pol ? lvl : ~lvl;
  endfunction : sensed

  ccc_sync #(.WIDTH(3)) u_sync (
    .clk    (ref_clk),
    .arst_n (arst_n),
    .din    ({sync_pin, hold_pin, clamp_pin}),
    .dout   (pin_s)
  );

  // configuration, reset values fixed by package
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q.clamp_src <= ccc_pkg::CLAMP_SRC_RST;
      cfg_q.clamp_pol <= ccc_pkg::CLAMP_POL_RST;
      cfg_q.hold_pol  <= ccc_pkg::HOLD_POL_RST;
      cfg_q.sync_pol  <= ccc_pkg::SYNC_POL_RST;
      cfg_q.clamp_dly <= ccc_pkg::DLY_RST;
      cfg_q.clamp_dur <= ccc_pkg::DUR_RST;
    end else if (cfg_we) begin
      cfg_q <= cfg;
    end
  end

  // sync edges in configured sense
  assign lead_edge  = fill_q[2] & sensed(pin_s[2], cfg_q.sync_pol) & ~sensed(sync_d1_q, cfg_q.sync_pol);
  assign trail_edge = fill_q[2] & ~sensed(pin_s[2], cfg_q.sync_pol) & sensed(sync_d1_q, cfg_q.sync_pol);

  // no edge until synchroniser and delay flop hold real samples
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fill_q <= '0;
    end else begin
      fill_q <= {fill_q[1:0], 1'b1};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_d1_q <= 1'b0;
    end else begin
      sync_d1_q <= pin_s[2];
    end
  end

  // internal clamp timer: delay then duration
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q  <= ccc_pkg::CCC_IDLE;
      cnt_q <= '0;
    end else if (trail_edge) begin
      if (cfg_q.clamp_dly == '0) begin
        st_q  <= (cfg_q.clamp_dur == '0) ? ccc_pkg::CCC_IDLE : ccc_pkg::CCC_CLAMP;
        cnt_q <= cfg_q.clamp_dur;
      end else begin
        st_q  <= ccc_pkg::CCC_DELAY;
        cnt_q <= cfg_q.clamp_dly;
      end
    end else begin
      case (st_q)
        ccc_pkg::CCC_DELAY: begin
          if (cnt_q == CW'(1)) begin
            st_q  <= (cfg_q.clamp_dur == '0) ? ccc_pkg::CCC_IDLE : ccc_pkg::CCC_CLAMP;
            cnt_q <= cfg_q.clamp_dur;
          end else begin
            cnt_q <= cnt_q - CW'(1);
          end
        end
        ccc_pkg::CCC_CLAMP: begin
          if (cnt_q == CW'(1)) begin
            st_q <= ccc_pkg::CCC_IDLE;
          end
          cnt_q <= cnt_q - CW'(1);
        end
        default: begin
          st_q <= ccc_pkg::CCC_IDLE;
        end
      endcase
    end
  end

  assign int_clamp = (st_q == ccc_pkg::CCC_CLAMP);
  assign ext_clamp = sensed(pin_s[0], cfg_q.clamp_pol);
  assign hold_act  = sensed(pin_s[1], cfg_q.hold_pol);

  // outputs: clamp window, pll hold, track and lead strobes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clamp_q <= 1'b0;
      hold_q  <= 1'b0;
      track_q <= 1'b0;
      lead_q  <= 1'b0;
    end else begin
      clamp_q <= cfg_q.clamp_src ? ext_clamp : int_clamp;
      hold_q  <= hold_act;
      track_q <= lead_edge & ~hold_act;
      lead_q  <= lead_edge;
    end
  end

  property p_int_clamp;
    @(posedge ref_clk) disable iff (!arst_n)
      !cfg_q.clamp_src && int_clamp |=> clamp_q;
  endproperty
  a_int_clamp: assert property (p_int_clamp) else $error("internal clamp not passed");

  property p_ext_clamp;
    @(posedge ref_clk) disable iff (!arst_n)
      cfg_q.clamp_src |=> clamp_q == $past(sensed(pin_s[0], cfg_q.clamp_pol));
  endproperty
  a_ext_clamp: assert property (p_ext_clamp) else $error("external clamp wrong");

  property p_ign_ext;
    @(posedge ref_clk) disable iff (!arst_n)
      !cfg_q.clamp_src && !int_clamp |=> !clamp_q;
  endproperty
  a_ign_ext: assert property (p_ign_ext) else $error("external clamp not ignored");

  property p_hold_sense;
    @(posedge ref_clk) disable iff (!arst_n)
      (pin_s[1] == cfg_q.hold_pol) |=> hold_q;
  endproperty
  a_hold_sense: assert property (p_hold_sense) else $error("hold sense wrong");

  property p_no_track;
    @(posedge ref_clk) disable iff (!arst_n)
      hold_act |=> !track_q;
  endproperty
  a_no_track: assert property (p_no_track) else $error("tracked during hold");

  property p_delay_len;
    @(posedge ref_clk) disable iff (!arst_n)
      trail_edge && !cfg_we && cfg_q.clamp_dly == 8'h02 && cfg_q.clamp_dur != 8'h00
        ##1 !trail_edge && !cfg_we ##1 !trail_edge
        |-> st_q == ccc_pkg::CCC_DELAY ##1 st_q == ccc_pkg::CCC_CLAMP;
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("delay count wrong");

  property p_lead_only;
    @(posedge ref_clk) disable iff (!arst_n)
      sync_d1_q != pin_s[2] && pin_s[2] != cfg_q.sync_pol |=> !lead_q;
  endproperty
  a_lead_only: assert property (p_lead_only) else $error("both edges taken");

  property p_lead_pulse;
    @(posedge ref_clk) disable iff (!arst_n)
      fill_q[2] && sync_d1_q != pin_s[2] && pin_s[2] == cfg_q.sync_pol |=> lead_q;
  endproperty
  a_lead_pulse: assert property (p_lead_pulse) else $error("leading edge missed");

  property p_track_free;
    @(posedge ref_clk) disable iff (!arst_n)
      lead_edge && !hold_act |=> track_q;
  endproperty
  a_track_free: assert property (p_track_free) else $error("track strobe missed");

  property p_hold_off;
    @(posedge ref_clk) disable iff (!arst_n)
      (pin_s[1] != cfg_q.hold_pol) |=> !hold_q;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("hold active when pin inactive");

  property p_dur_one;
    @(posedge ref_clk) disable iff (!arst_n)
      trail_edge && !cfg_we && cfg_q.clamp_dly == '0 && cfg_q.clamp_dur == CW'(1)
        |=> st_q == ccc_pkg::CCC_CLAMP ##1 st_q == ccc_pkg::CCC_IDLE;
  endproperty
  a_dur_one: assert property (p_dur_one) else $error("duration count wrong");

  property p_dur_zero;
    @(posedge ref_clk) disable iff (!arst_n)
      trail_edge && cfg_q.clamp_dly == '0 && cfg_q.clamp_dur == '0 |=> st_q == ccc_pkg::CCC_IDLE;
  endproperty
  a_dur_zero: assert property (p_dur_zero) else $error("zero duration clamped");

  property p_rst_vals;
    @(posedge ref_clk) $rose(arst_n) |-> !cfg_q.clamp_src && cfg_q.hold_pol;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset config wrong");
endmodule : ccc_top
`default_nettype wire

// >>> ccc_line.sv
// line sync source standing in for the graphics source
// assumes: one sync pulse per PER pixel clocks, leading edge per pol
`timescale 1ns/1ps
`default_nettype none
module ccc_line #(
  parameter int PER = 100,
  parameter int WID = 10
) (
  input  wire logic ref_clk,
  input  wire logic pol,
  output var  logic sync_pin
);
  int cnt = 0;
  always @(posedge ref_clk) begin
    #1;
    cnt = (cnt == PER - 1) ? 0 : cnt + 1;
    sync_pin = pol ? (cnt < WID) : (cnt >= WID);
  end
endmodule : ccc_line
`default_nettype wire

// >>> tb.sv
// testbench for the clamp and hold control block
// assumes: ccc_line drives sync; one 100-cycle line per window
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic              ref_clk = 1'b0, arst_n = 1'b0, clamp_pin = 1'b0, hold_pin = 1'b0, cfg_we = 1'b0;
  logic              sync_pin, clamp_q, hold_q, track_q, lead_q;
  ccc_pkg::ccc_cfg_t cfg = '0, cfg_q;
  int                bad_count = 0, checks_done = 0, cyc = 0, n_cl = 0, n_ld = 0, n_tr = 0;
  always #20 ref_clk = ~ref_clk;
  ccc_line #(.PER(100), .WID(10)) src (.ref_clk(ref_clk), .pol(cfg.sync_pol), .sync_pin(sync_pin));
  ccc_top DUT (.ref_clk(ref_clk), .arst_n(arst_n), .clamp_pin(clamp_pin), .hold_pin(hold_pin),
    .sync_pin(sync_pin), .cfg(cfg), .cfg_we(cfg_we), .clamp_q(clamp_q), .hold_q(hold_q),
    .track_q(track_q), .lead_q(lead_q), .cfg_q(cfg_q));
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    n_cl <= n_cl + int'(clamp_q === 1'b1);
    n_ld <= n_ld + int'(lead_q === 1'b1);
    n_tr <= n_tr + int'(track_q === 1'b1);
    if (cyc == 4000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task automatic setc(input logic [19:0] c);
    @(posedge ref_clk) #1;
    cfg = c;
    cfg_we = 1'b1;
    @(posedge ref_clk) #1;
    cfg_we = 1'b0;
  endtask : setc
  // settle one line, then count pulses over exactly one line
  task automatic line(input int cl, input int ld, input int tr);
    int a, b, c;
    repeat (100) @(posedge ref_clk);
    a = n_cl;
    b = n_ld;
    c = n_tr;
    repeat (100) @(posedge ref_clk);
    chk(n_cl - a, cl);
    chk(n_ld - b, ld);
    chk(n_tr - c, tr);
  endtask : line
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    chk(cfg_q, 20'h60914);
    clamp_pin = 1'b1;
    setc(20'h60914);
    line(20, 1, 1);
    setc(20'h60001);
    line(1, 1, 1);
    setc(20'h60203);
    chk(cfg_q, 20'h60203);
    line(3, 1, 1);
    setc(20'h75003);
    line(3, 1, 1);
    setc(20'h70000);
    line(0, 1, 1);
    setc(20'hE0914);
    @(posedge ref_clk) #1 clamp_pin = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk(clamp_q, 1'b1);
    @(posedge ref_clk) #1 chk(clamp_q, 1'b0);
    setc(20'hA0914);
    line(100, 1, 1);
    #1 clamp_pin = 1'b0;
    hold_pin = 1'b1;
    setc(20'h60914);
    line(20, 1, 0);
    #1 chk(hold_q, 1'b1);
    setc(20'h40914);
    line(20, 1, 1);
    #1 chk(hold_q, 1'b0);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
